// [pkg/iocd_pkg.sv]
// package: command codes, configuration carriers and reset values for the iris config decoder
package iocd_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_IRIS_PRESET_SPEED = 4'h1;
  localparam logic [3:0] CMD_IRIS_SIGNAL_MOTOR = 4'h2;
  localparam logic [3:0] CMD_IRIS_PRESET_POS   = 4'h3;
  localparam logic [3:0] CMD_IRIS_SIGNAL_SERVO = 4'h4;
  localparam logic [3:0] CMD_IRIS_SPEED_MODE   = 4'h5;
  localparam logic [3:0] CMD_IRIS_POS_MODE     = 4'h6;
  localparam logic [3:0] CMD_ZOOM_POS_MODE     = 4'h7;
  localparam logic [3:0] CMD_FOCUS_POS_MODE    = 4'h8;
  localparam logic [3:0] CMD_ZOOM_PRESET_POS   = 4'h9;
  localparam logic [3:0] CMD_FOCUS_PRESET_POS  = 4'hA;
  localparam logic [3:0] CMD_ZOOM_SIGNAL_SERVO = 4'hB;
  localparam logic [3:0] CMD_FOCUS_SIGNAL_SERVO = 4'hC;
  localparam logic [3:0] CMD_SERVO_LENS_MACRO  = 4'hD;

  // ---------------------------------------------------------------
  // macro expansion
  // ---------------------------------------------------------------
  localparam int unsigned MACRO_STEPS   = 9;
  localparam logic [3:0]  MACRO_LAST    = 4'h8;

  // ---------------------------------------------------------------
  // per-axis configuration (zoom, focus, iris)
  // ---------------------------------------------------------------
  typedef struct packed {
    logic servo_signal;   // 1 servomotor output, 0 motor output
    logic speed_preset;   // 1 speed presets, 0 positional presets
    logic speed_mode;     // 1 speed lens mode, 0 positional lens mode
  } iocd_axis_cfg_t;

  typedef struct packed {
    iocd_axis_cfg_t zoom;
    iocd_axis_cfg_t focus;
    iocd_axis_cfg_t iris;
  } iocd_lens_cfg_t;

  localparam logic           RST_SERVO_SIGNAL = 1'b1;
  localparam logic           RST_SPEED_PRESET = 1'b0;
  localparam logic           RST_SPEED_MODE   = 1'b0;
  localparam iocd_axis_cfg_t RST_AXIS_CFG =
    '{servo_signal: RST_SERVO_SIGNAL, speed_preset: RST_SPEED_PRESET,
      speed_mode: RST_SPEED_MODE};

endpackage

// [design/iocd_macro_seq.sv]
// servo lens macro sequencer: steps through the nine sub-commands one per clock
`timescale 1ns/100ps
module iocd_macro_seq (
  input  wire logic       mclk,       // 200 MHz clock
  input  wire logic       reset_n,    // async reset, active low
  input  wire logic       start,      // one-cycle start pulse
  output logic            busy,       // sequence running
  output logic            sub_valid,  // sub-command valid this cycle
  output logic [3:0]      sub_cmd     // sub-command code
);

  logic [3:0] step_q;
  logic       busy_q;

  // ---------------------------------------------------------------
  // step counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_q <= 1'b0;
      step_q <= 4'h0;
    end
    else if (!busy_q)
    begin
      busy_q <= start;
      step_q <= 4'h0;
    end
    else
    begin
      if (step_q == iocd_pkg::MACRO_LAST)
        busy_q <= 1'b0;
      step_q <= step_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // sub-command order: modes, presets, then signals
  // ---------------------------------------------------------------
  always_comb
  begin
    case (step_q)
      4'h0:    sub_cmd = iocd_pkg::CMD_ZOOM_POS_MODE;
      4'h1:    sub_cmd = iocd_pkg::CMD_FOCUS_POS_MODE;
      4'h2:    sub_cmd = iocd_pkg::CMD_IRIS_POS_MODE;
      4'h3:    sub_cmd = iocd_pkg::CMD_ZOOM_PRESET_POS;
      4'h4:    sub_cmd = iocd_pkg::CMD_FOCUS_PRESET_POS;
      4'h5:    sub_cmd = iocd_pkg::CMD_IRIS_PRESET_POS;
      4'h6:    sub_cmd = iocd_pkg::CMD_ZOOM_SIGNAL_SERVO;
      4'h7:    sub_cmd = iocd_pkg::CMD_FOCUS_SIGNAL_SERVO;
      4'h8:    sub_cmd = iocd_pkg::CMD_IRIS_SIGNAL_SERVO;
      default: sub_cmd = 4'h0;
    endcase
  end

  assign busy      = busy_q;
  assign sub_valid = busy_q;

endmodule

// [design/iocd_top.sv]
// iris output configuration decoder: applies lens configuration commands
`timescale 1ns/100ps
// Function
// - speed-preset command makes iris presets recall as speed values
// - speed-preset needs servo signal config and selector in servo position
// - motor-signal command configures iris output as motor drive
// - positional-preset command recalls positional presets; positional is default
// - positional-preset applies only while servo signal config is in effect
// - servo-signal command configures iris output as servomotor output
// - speed-mode command sets iris mode to speed, only in servo mode
// - speed-mode command needs mode-select lines of lens connector wired
// - servo lens macro issues nine positional/servo sub-commands in one operation
// - positional-mode command sets iris mode positional (default), servo mode only
module iocd_top (
  input  wire logic                     mclk,            // 200 MHz clock
  input  wire logic                     reset_n,         // async reset, active low
  input  wire logic                     cmd_valid,       // command strobe, one cycle
  input  wire logic [3:0]               cmd_code,        // command code
  output logic                          cmd_ready,       // low while macro runs
  output logic                          cmd_rejected,    // pulse: command ignored
  input  wire logic                     iris_sel_servo,  // selector pin, 1 = servo position
  input  wire logic                     mode_lines_wired,// mode-select lines wired strap
  output iocd_pkg::iocd_lens_cfg_t      lens_cfg,        // full lens configuration
  output logic                          iris_servo_out,  // iris output is servomotor
  output logic                          iris_speed_preset// iris presets recall as speed
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic sel_meta_q, sel_q, wired_meta_q, wired_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_meta_q   <= 1'b0;
      sel_q        <= 1'b0;
      wired_meta_q <= 1'b0;
      wired_q      <= 1'b0;
    end
    else
    begin
      sel_meta_q   <= iris_sel_servo;
      sel_q        <= sel_meta_q;
      wired_meta_q <= mode_lines_wired;
      wired_q      <= wired_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // macro sequencer
  // ---------------------------------------------------------------
  logic       mac_busy, mac_valid;
  logic [3:0] mac_cmd;
  logic       ext_take;

  assign cmd_ready = !mac_busy;
  assign ext_take  = cmd_valid && !mac_busy;

  iocd_macro_seq u_macro (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .start     (ext_take && (cmd_code == iocd_pkg::CMD_SERVO_LENS_MACRO)),
    .busy      (mac_busy),
    .sub_valid (mac_valid),
    .sub_cmd   (mac_cmd)
  );

  // ---------------------------------------------------------------
  // command select and acceptance
  // ---------------------------------------------------------------
  logic                     act_valid;
  logic [3:0]               act_cmd;
  logic                     accept;
  iocd_pkg::iocd_lens_cfg_t cfg_q, cfg_d;

  assign act_valid = mac_valid || ext_take;
  assign act_cmd   = mac_valid ? mac_cmd : cmd_code;

  always_comb
  begin
    cfg_d  = cfg_q;
    accept = 1'b1;
    case (act_cmd)
      iocd_pkg::CMD_IRIS_PRESET_SPEED:
      begin
        accept = cfg_q.iris.servo_signal && sel_q;
        if (accept)
          cfg_d.iris.speed_preset = 1'b1;
      end
      iocd_pkg::CMD_IRIS_PRESET_POS:
      begin
        accept = cfg_q.iris.servo_signal;
        if (accept)
          cfg_d.iris.speed_preset = 1'b0;
      end
      iocd_pkg::CMD_IRIS_SIGNAL_MOTOR:
        cfg_d.iris.servo_signal = 1'b0;
      iocd_pkg::CMD_IRIS_SIGNAL_SERVO:
        cfg_d.iris.servo_signal = 1'b1;
      iocd_pkg::CMD_IRIS_SPEED_MODE:
      begin
        accept = cfg_q.iris.servo_signal && wired_q;
        if (accept)
          cfg_d.iris.speed_mode = 1'b1;
      end
      iocd_pkg::CMD_IRIS_POS_MODE:
      begin
        accept = cfg_q.iris.servo_signal && wired_q;
        if (accept)
          cfg_d.iris.speed_mode = 1'b0;
      end
      iocd_pkg::CMD_ZOOM_POS_MODE:
      begin
        accept = cfg_q.zoom.servo_signal && wired_q;
        if (accept)
          cfg_d.zoom.speed_mode = 1'b0;
      end
      iocd_pkg::CMD_FOCUS_POS_MODE:
      begin
        accept = cfg_q.focus.servo_signal && wired_q;
        if (accept)
          cfg_d.focus.speed_mode = 1'b0;
      end
      iocd_pkg::CMD_ZOOM_PRESET_POS:
      begin
        accept = cfg_q.zoom.servo_signal;
        if (accept)
          cfg_d.zoom.speed_preset = 1'b0;
      end
      iocd_pkg::CMD_FOCUS_PRESET_POS:
      begin
        accept = cfg_q.focus.servo_signal;
        if (accept)
          cfg_d.focus.speed_preset = 1'b0;
      end
      iocd_pkg::CMD_ZOOM_SIGNAL_SERVO:
        cfg_d.zoom.servo_signal = 1'b1;
      iocd_pkg::CMD_FOCUS_SIGNAL_SERVO:
        cfg_d.focus.servo_signal = 1'b1;
      iocd_pkg::CMD_SERVO_LENS_MACRO:
        accept = 1'b1;
      default:
        accept = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // configuration state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q.zoom  <= iocd_pkg::RST_AXIS_CFG;
      cfg_q.focus <= iocd_pkg::RST_AXIS_CFG;
      cfg_q.iris  <= iocd_pkg::RST_AXIS_CFG;
    end
    else if (act_valid)
      cfg_q <= cfg_d;
  end

  // ---------------------------------------------------------------
  // reject flag
  // ---------------------------------------------------------------
  logic rej_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rej_q <= 1'b0;
    else
      rej_q <= act_valid && !accept;
  end

  assign cmd_rejected      = rej_q;
  assign lens_cfg          = cfg_q;
  assign iris_servo_out    = cfg_q.iris.servo_signal;
  assign iris_speed_preset = cfg_q.iris.speed_preset;

endmodule

// [verif/iocd_top_asserts.sv]
// checker: port properties of the iris config decoder
`timescale 1ns/100ps
module iocd_top_asserts (
  input wire logic                     mclk,              // clock
  input wire logic                     reset_n,           // reset, active low
  input wire logic                     cmd_valid,         // strobe
  input wire logic [3:0]               cmd_code,          // code
  input wire logic                     cmd_ready,         // ready
  input wire logic                     cmd_rejected,      // reject pulse
  input wire iocd_pkg::iocd_lens_cfg_t lens_cfg,          // configuration
  input wire logic                     iris_servo_out,    // iris servo
  input wire logic                     iris_speed_preset  // iris speed presets
);
  wire logic tk = cmd_valid && cmd_ready;
  wire logic srv = lens_cfg.iris.servo_signal;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_motor_sig: assert property (tk && cmd_code == 4'h2 |=> !iris_servo_out)
    else $error("iris output not motor");
  chk_servo_sig: assert property (tk && cmd_code == 4'h4 |=> iris_servo_out)
    else $error("iris output not servo");
  chk_pos_preset: assert property (tk && cmd_code == 4'h3 && srv |=> !iris_speed_preset)
    else $error("positional preset not set");
  chk_preset_refuse: assert property (tk && cmd_code inside {4'h1, 4'h3} && !srv
    |=> cmd_rejected && $stable(lens_cfg)) else $error("preset taken in motor");
  chk_mode_refuse: assert property (tk && cmd_code inside {4'h5, 4'h6} && !srv
    |=> cmd_rejected && $stable(lens_cfg)) else $error("mode taken in motor");
  chk_bad_code: assert property (tk && cmd_code inside {4'h0, 4'hE, 4'hF}
    |=> cmd_rejected && $stable(lens_cfg)) else $error("unknown code taken");
  chk_macro_busy: assert property (tk && cmd_code == 4'hD
    |=> !cmd_ready [*8] ##1 !cmd_ready ##1 cmd_ready) else $error("macro length wrong");
  chk_macro_end: assert property (tk && cmd_code == 4'hD |-> ##10
    lens_cfg.zoom.servo_signal && lens_cfg.focus.servo_signal && srv)
    else $error("macro left a motor axis");
endmodule

// [verif/iocd_ctrl_model.sv]
// controller model: issues command strobes to the decoder
`timescale 1ns/100ps
module iocd_ctrl_model (
  input  wire logic       mclk,      // clock
  input  wire logic       cmd_ready, // decoder takes commands
  output logic            cmd_valid, // strobe
  output logic [3:0]      cmd_code   // code
);
  // counts strobes that gave up waiting for ready
  int n_stall;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    n_stall = 0;
  end
  // strobe held until an edge that sees ready high
  task automatic send(input logic [3:0] c);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(negedge mclk);
    while (cmd_ready !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40)
      n_stall++;
    @(posedge mclk);
  endtask
  // released code lines show the inverse of the last code
  task automatic idle(input int k);
    cmd_valid <= 1'b0;
    cmd_code <= ~cmd_code;
    repeat (k) @(posedge mclk);
  endtask
endmodule

// [verif/test_iris_output_config_decoder.sv]
// bench: directed and random commands against a reference model
`timescale 1ns/100ps
module test_iris_output_config_decoder;
  logic                     mclk, reset_n, cmd_valid, cmd_ready, cmd_rejected;
  logic                     iris_sel_servo, mode_lines_wired;
  logic                     iris_servo_out, iris_speed_preset;
  logic [3:0]               cmd_code;
  iocd_pkg::iocd_lens_cfg_t lens_cfg;
  int                       n_mismatch, samples_checked, seed;
  int                       s[3], p[3], m[3];
  int                       k, rj, sl1, sl2, wr1, wr2;
  logic [3:0]               sub[9] = '{4'h7, 4'h8, 4'h6, 4'h9, 4'hA, 4'h3, 4'hB, 4'hC, 4'h4};
  iocd_top u_iocd_top (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .cmd_valid         (cmd_valid),
    .cmd_code          (cmd_code),
    .cmd_ready         (cmd_ready),
    .cmd_rejected      (cmd_rejected),
    .iris_sel_servo    (iris_sel_servo),
    .mode_lines_wired  (mode_lines_wired),
    .lens_cfg          (lens_cfg),
    .iris_servo_out    (iris_servo_out),
    .iris_speed_preset (iris_speed_preset)
  );
  iocd_ctrl_model u_ctrl (
    .mclk      (mclk),
    .cmd_ready (cmd_ready),
    .cmd_valid (cmd_valid),
    .cmd_code  (cmd_code)
  );
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic int step(input logic [3:0] c);
    int a;
    a = (c inside {4'h8, 4'hA, 4'hC}) ? 1 : (c inside {4'h7, 4'h9, 4'hB}) ? 0 : 2;
    step = 0;
    case (c)
      4'h1: if (s[2] && sl2) p[2] = 1; else step = 1;
      4'h2: s[2] = 0;
      4'h4, 4'hB, 4'hC: s[a] = 1;
      4'h3, 4'h9, 4'hA: if (s[a]) p[a] = 0; else step = 1;
      4'h5, 4'h6, 4'h7, 4'h8: if (s[a] && wr2) m[a] = (c == 4'h5); else step = 1;
      default: step = 1;
    endcase
  endfunction
  always @(posedge mclk)
  begin
    rj = 0;
    if (!reset_n)
    begin
      s = '{1, 1, 1};
      p = '{0, 0, 0};
      m = '{0, 0, 0};
      k = 9;
    end
    else if (k < 9)
    begin
      rj = step(sub[k]);
      k++;
    end
    else if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      if (cmd_code === 4'hD) k = 0;
      else rj = step(cmd_code);
    sl2 = sl1;
    sl1 = iris_sel_servo;
    wr2 = wr1;
    wr1 = mode_lines_wired;
  end
  task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(negedge mclk)
    if (reset_n === 1'b1)
    begin
      cmp("lens_cfg", {s[0][0], p[0][0], m[0][0], s[1][0], p[1][0], m[1][0], s[2][0], p[2][0],
        m[2][0]}, lens_cfg);
      cmp("cmd_rejected", 9'(rj), 9'(cmd_rejected));
      cmp("cmd_ready", 9'(k >= 9), 9'(cmd_ready));
      cmp("iris_out", {7'h0, s[2][0], p[2][0]}, {7'h0, iris_servo_out, iris_speed_preset});
    end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    seed = 11;
    n_mismatch = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    iris_sel_servo = 1'b1;
    mode_lines_wired = 1'b1;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    u_ctrl.idle(4);
    for (int c = 0; c < 16; c++) u_ctrl.send(4'(c));
    u_ctrl.send(4'h2);
    u_ctrl.send(4'hD);
    u_ctrl.send(4'hD);
    repeat (300)
    begin
      // selector mostly agrees with the iris output type
      iris_sel_servo <= ($random(seed) & 3) ? s[2][0] : !s[2][0];
      mode_lines_wired <= ($random(seed) & 3) != 0;
      u_ctrl.idle(3);
      u_ctrl.send(4'($random(seed)));
    end
    u_ctrl.idle(12);
    cmp("send_stall", 9'h0, 9'(u_ctrl.n_stall));
    tally_and_finish();
  end
endmodule
bind iocd_top iocd_top_asserts u_chk (
  .mclk              (mclk),
  .reset_n           (reset_n),
  .cmd_valid         (cmd_valid),
  .cmd_code          (cmd_code),
  .cmd_ready         (cmd_ready),
  .cmd_rejected      (cmd_rejected),
  .lens_cfg          (lens_cfg),
  .iris_servo_out    (iris_servo_out),
  .iris_speed_preset (iris_speed_preset)
);
